// *** wcrc_host.sv ***
/*
 * host-side write framer: buffers user write bursts, computes the checksum
 * per byte lane and drives ten-slot frames onto the device data pins, then
 * watches the device alert and, with masking off, asks the user to rewrite failing bursts.
 * assumes one 200 MHz clock; device pins are synchronous to it.
 */
`timescale 1ns/1ps
`default_nettype none
module wcrc_host
	import wcrc_pkg::*;
#(
	parameter int DEPTH = FIFO_DEPTH
) (
	input  wire logic          clk,
	input  wire logic          rst_n,
	input  wire wr_cfg_t       cfg,
	input  wire logic          wr_valid,
	output var  logic          wr_ready,
	input  wire logic [127:0]  wr_data,
	input  wire logic [15:0]   wr_mask,
	input  wire logic          mpr_wr_req,
	input  wire logic          per_dev_req,
	output logic               cfg_error,
	output logic               req_refused,
	output logic [15:0]        dq_out,
	output logic               dq_oe,
	output logic [1:0]         side_out,
	output logic               wr_cmd,
	output logic [2:0]         wr_col,
	output logic [15:0]        crc_sent,
	input  wire logic          alert_n,
	output logic               rewrite_req
);
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_SEND = 3'b010,
		ST_GAP  = 3'b100
	} st_t;

	wr_word_t    fin, fout;
	logic        f_valid, f_pop;
	logic [7:0]  crc_lo, crc_hi;
	st_t         st_r, st_nxt;
	logic [3:0]  slot_r, slot_nxt;
	logic [3:0]  gap_r, gap_nxt;
	wr_word_t    cur_r, cur_nxt;
	logic [15:0] crc_r, crc_nxt;
	logic [15:0] dq_nxt;
	logic [1:0]  side_nxt;
	logic        oe_nxt, cmd_nxt, rew_nxt, cfgerr_nxt, refused_nxt;
	logic        bad_spacing;
	logic [3:0]  gap_need;

	////////////////////////////////////////////////////////////////////////
	assign fin = '{data: wr_data, side: wr_mask};

	wcrc_fifo #(.WIDTH(WORD_W), .DEPTH(DEPTH)) u_fifo (
		.clk       (clk),
		.rst_n     (rst_n),
		.in_valid  (wr_valid),
		.in_ready  (wr_ready),
		.in_data   (fin),
		.out_valid (f_valid),
		.out_ready (f_pop),
		.out_data  (fout)
	);

	// side bits are only used when masking or inversion is enabled
	wcrc_lane_tree u_lo (
		.data      (fout.data[63:0]),
		.side      (fout.side[7:0]),
		.side_used (cfg.mask_en | cfg.inv_en),
		.four_bit  (cfg.width == WIDTH_X4),
		.chop      (cfg.chop),
		.col2      (cfg.col2),
		.crc       (crc_lo)
	);

	wcrc_lane_tree u_hi (
		.data      (fout.data[127:64]),
		.side      (fout.side[15:8]),
		.side_used (cfg.mask_en | cfg.inv_en),
		.four_bit  (1'b0),
		.chop      (cfg.chop),
		.col2      (cfg.col2),
		.crc       (crc_hi)
	);

	////////////////////////////////////////////////////////////////////////
	// spacing: a gap equal to the forbidden value is stretched by one clock
	assign gap_need    = cfg.pre2 ? 4'(SPACE_PRE2 - SLOTS / 2 + 1) : 4'(SPACE_PRE1 - SLOTS / 2 + 1);
	assign bad_spacing = cfg.crc_en && (cfg.mask_en && cfg.inv_en);

	always_comb begin
		st_nxt      = st_r;
		slot_nxt    = slot_r;
		gap_nxt     = gap_r;
		cur_nxt     = cur_r;
		crc_nxt     = crc_r;
		dq_nxt      = '1;
		side_nxt    = '1;
		oe_nxt      = 1'b0;
		cmd_nxt     = 1'b0;
		f_pop       = 1'b0;
		cfgerr_nxt  = bad_spacing;
		refused_nxt = cfg.crc_en & (mpr_wr_req | per_dev_req);
		rew_nxt     = ~alert_n & cfg.crc_en & ~cfg.mask_en;
		case (st_r)
			ST_IDLE: begin
				if (f_valid && !bad_spacing) begin
					f_pop    = 1'b1;
					cur_nxt  = fout;
					crc_nxt  = {crc_hi, crc_lo};
					cmd_nxt  = 1'b1;
					slot_nxt = '0;
					st_nxt   = ST_SEND;
				end
			end
			ST_SEND: begin
				oe_nxt = 1'b1;
				for (int l = 0; l < 16; l++) begin
					if (slot_r < 4'(BEATS) && !cfg.chop) begin
						dq_nxt[l] = cur_r.data[l*8+slot_r[2:0]];
					end else if (slot_r < 4'(BEATS)) begin
						// chopped: four beats, chosen nibble first, ones after
						dq_nxt[l] = slot_r[2] | cur_r.data[l*8+{cfg.col2, slot_r[1:0]}];
					end else if (slot_r == 4'(BEATS) && cfg.crc_en) begin
						dq_nxt[l] = (cfg.width == WIDTH_X4 && l < 4) ? crc_r[l] : crc_r[(l/8)*8+(l%8)];
					end else if (cfg.width == WIDTH_X4 && l < 4 && cfg.crc_en) begin
						dq_nxt[l] = crc_r[l+4];
					end else begin
						dq_nxt[l] = 1'b1;
					end
				end
				for (int s = 0; s < 2; s++) begin
					// unused mask pins carry ones, as the checksum tree assumes
					if (slot_r < 4'(BEATS) && (cfg.mask_en || cfg.inv_en)) begin
						if (cfg.chop) begin
							side_nxt[s] = slot_r[2] | cur_r.side[s*8+{cfg.col2, slot_r[1:0]}];
						end else begin
							side_nxt[s] = cur_r.side[s*8+slot_r[2:0]];
						end
					end
				end
				if (slot_r == 4'((cfg.crc_en ? SLOTS : BEATS) - 1)) begin
					st_nxt  = ST_GAP;
					gap_nxt = cfg.crc_en ? gap_need : 4'h1;
				end else begin
					slot_nxt = slot_r + 4'h1;
				end
			end
			ST_GAP: begin
				if (gap_r <= 4'h1) begin
					st_nxt = ST_IDLE;
				end else begin
					gap_nxt = gap_r - 4'h1;
				end
			end
			default: st_nxt = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r        <= ST_IDLE;
			slot_r      <= '0;
			gap_r       <= '0;
			cur_r       <= '0;
			crc_r       <= '0;
			dq_out      <= '1;
			dq_oe       <= 1'b0;
			side_out    <= '1;
			wr_cmd      <= 1'b0;
			wr_col      <= BURST_COL;
			crc_sent    <= '0;
			rewrite_req <= 1'b0;
			cfg_error   <= 1'b0;
			req_refused <= 1'b0;
		end else begin
			st_r        <= st_nxt;
			slot_r      <= slot_nxt;
			gap_r       <= gap_nxt;
			cur_r       <= cur_nxt;
			crc_r       <= crc_nxt;
			dq_out      <= dq_nxt;
			dq_oe       <= oe_nxt;
			side_out    <= side_nxt;
			wr_cmd      <= cmd_nxt;
			wr_col      <= BURST_COL;
			crc_sent    <= crc_nxt;
			rewrite_req <= rew_nxt;
			cfg_error   <= cfgerr_nxt;
			req_refused <= refused_nxt;
		end
	end
endmodule : wcrc_host
`default_nettype wire

// *** wcrc_pkg.sv ***
/*
 * package for the host-side write-data checksum framer: burst frame layout,
 * modes, timing counts and the serial crc-8 step.
 * assumes a single 200 MHz clock domain; the memory device is outside.
 */
// Summary of operation
// - host computes 8-bit checksum over 72-bit tree and sends it with write data
// - four-bit part: 32 data bits feed tree, upper 40 inputs held at one
// - byte part: 64 data bits plus 8 mask/inversion bits, ones when unused
// - byte and sixteen-bit parts: host drives ones in transfer slot nine
// - masking off: device may commit early, host rewrites data after an error
// - write inversion and masking never enabled together; host flags the clash only with checksum on
// - checksum on with one-clock preamble: no write spacing of 4 clocks
// - checksum on with two-clock preamble: no write spacing of 6 clocks
// - checksum on: no multipurpose register writes, no per-device addressing
// - crc-8 polynomial x^8+x^2+x+1 over 72 bits
// - zero initial value, data bit 71 is the first serial bit
// - fixed eight-beat bursts use sequential order, low column bits zero
// - byte part chopped burst: 36 tree inputs, unused inputs at one
// - chopped burst with column bit two set: upper nibble feeds lower nibble
package wcrc_pkg;

	localparam int          TREE_W       = 72;
	localparam int          CRC_W        = 8;
	localparam int          LANE_BITS    = 8;
	localparam int          BEATS        = 8;
	localparam int          SLOTS        = 10;
	localparam logic [7:0]  CRC_POLY     = 8'h07;
	localparam logic [7:0]  CRC_INIT     = 8'h00;
	localparam int          SPACE_PRE1   = 4;
	localparam int          SPACE_PRE2   = 6;
	localparam int          FIFO_DEPTH   = 16;
	localparam logic [2:0]  BURST_COL    = 3'h0;

	typedef enum logic [1:0] {
		WIDTH_X4  = 2'h0,
		WIDTH_X8  = 2'h1,
		WIDTH_X16 = 2'h2
	} part_width_t;

	typedef struct packed {
		part_width_t width;
		logic        crc_en;
		logic        mask_en;
		logic        inv_en;
		logic        chop;
		logic        col2;
		logic        pre2;
	} wr_cfg_t;

	typedef struct packed {
		logic [127:0] data;
		logic [15:0]  side;
	} wr_word_t;

	localparam int WORD_W = $bits(wr_word_t);

	// serial step, msb first: d[71] enters first
	function automatic logic [7:0] crc8_d72(input logic [71:0] d);
		logic [7:0] c;
		c = CRC_INIT;
		for (int i = 71; i >= 0; i--) begin
			c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? CRC_POLY : 8'h00);
		end
		return c;
	endfunction : crc8_d72

endpackage : wcrc_pkg

// *** wcrc_fifo.sv ***
/*
 * holds the small synchronous fifo that buffers write bursts.
 * assumes one clock; valid/ready on both sides; read data taken combinationally from storage.
 */
`timescale 1ns/1ps
`default_nettype none
module wcrc_fifo #(
	parameter int WIDTH = 144,
	parameter int DEPTH = 16
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             in_valid,
	output var  logic             in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output var  logic             out_valid,
	input  wire logic             out_ready,
	output var  logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wp_r, wp_nxt, rp_r, rp_nxt;
	logic [AW:0]      cnt_r, cnt_nxt;
	logic             push, pop;
	logic             ready_r, ready_nxt;

	////////////////////////////////////////////////////////////////////////
	// registered so the top-level ready comes straight from a flop
	assign in_ready  = ready_r;
	assign out_valid = (cnt_r != '0);
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;
	assign out_data  = mem[rp_r];

	always_comb begin
		wp_nxt  = push ? wp_r + 1'b1 : wp_r;
		rp_nxt  = pop ? rp_r + 1'b1 : rp_r;
		cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
		ready_nxt = (cnt_nxt != (AW+1)'(DEPTH));
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wp_r  <= '0;
			rp_r  <= '0;
			cnt_r <= '0;
			ready_r <= 1'b0;
		end else begin
			wp_r  <= wp_nxt;
			rp_r  <= rp_nxt;
			cnt_r <= cnt_nxt;
			ready_r <= ready_nxt;
		end
	end

	// storage has no reset; only written words are ever read
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wp_r] <= in_data;
		end
	end
endmodule : wcrc_fifo
`default_nettype wire

// *** wcrc_lane_tree.sv ***
/*
 * holds one 72-bit checksum tree input mapper for a byte lane.
 * assumes the caller supplies lane data, mask/inversion bits and mode.
 */
`timescale 1ns/1ps
`default_nettype none
module wcrc_lane_tree
	import wcrc_pkg::*;
(
	input  wire logic [63:0] data,
	input  wire logic [7:0]  side,
	input  wire logic        side_used,
	input  wire logic        four_bit,
	input  wire logic        chop,
	input  wire logic        col2,
	output var  logic [7:0]  crc
);
	logic [71:0] tree;

	// tree bit 8*lane+beat; chopped bursts keep four beats, rest read as one
	always_comb begin
		tree = {TREE_W{1'b1}};
		for (int l = 0; l < 9; l++) begin
			for (int b = 0; b < BEATS; b++) begin
				if (l < 8) begin
					if (!(four_bit && l >= 4)) begin
						if (!chop) begin
							tree[l*8+b] = data[l*8+b];
						end else if (b < 4) begin
							tree[l*8+b] = col2 ? data[l*8+b+4] : data[l*8+b];
						end
					end
				end else if (side_used && !four_bit) begin
					if (!chop) begin
						tree[64+b] = side[b];
					end else if (b < 4) begin
						tree[64+b] = col2 ? side[b+4] : side[b];
					end
				end
			end
		end
		crc = crc8_d72(tree);
	end
endmodule : wcrc_lane_tree
`default_nettype wire

// *** wcrc_host_checker.sv ***
/* port assertions for the host write framer.
   assumes a bind onto wcrc_host, one clock, crc slots framed after wr_cmd. */
`timescale 1ns/1ps
`default_nettype none
module wcrc_host_checker
	import wcrc_pkg::*;
(
	input wire logic clk, rst_n, mpr_wr_req, per_dev_req, cfg_error, req_refused,
	input wire logic dq_oe, wr_cmd, alert_n, rewrite_req,
	input wire wr_cfg_t cfg,
	input wire logic [15:0] dq_out, crc_sent,
	input wire logic [1:0] side_out,
	input wire logic [2:0] wr_col
);
	// holds k+1 while slot k is on the pins; a new command reloads it
	logic [3:0] slot_r, slot_nxt;
	always_comb begin
		slot_nxt = 4'h0;
		if (wr_cmd)
			slot_nxt = 4'h1;
		else if (slot_r != 4'h0 && slot_r < 4'hb)
			slot_nxt = slot_r + 4'h1;
	end
	always_ff @(posedge clk or negedge rst_n)
		if (!rst_n)
			slot_r <= 4'h0;
		else
			slot_r <= slot_nxt;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	chk_col_zero: assert property (wr_cmd |-> wr_col == 3'h0) else $error("column");
	chk_frame_len: assert property (wr_cmd && cfg.crc_en |=> dq_oe [*8] ##1 dq_oe [*2]) else $error("frame");
	chk_cmd_gap: assert property (wr_cmd && cfg.crc_en |-> ##4 !wr_cmd ##2 !wr_cmd) else $error("spacing");
	chk_crc_slot: assert property (slot_r == 4'h9 && cfg.crc_en && cfg.width == WIDTH_X16
		|-> dq_out == crc_sent && side_out == 2'h3) else $error("crc slot");
	chk_ones_slot: assert property (slot_r == 4'ha && cfg.crc_en && cfg.width != WIDTH_X4
		|-> dq_out[7:0] == 8'hff && side_out[0]) else $error("slot nine");
	chk_refuse_req: assert property (cfg.crc_en && (mpr_wr_req || per_dev_req) |=> req_refused) else $error("refuse");
	chk_mode_clash: assert property (cfg.crc_en && cfg.mask_en && cfg.inv_en |=> cfg_error && !wr_cmd)
		else $error("clash");
	chk_rewrite_ask: assert property ($fell(alert_n) && cfg.crc_en && !cfg.mask_en |=> rewrite_req)
		else $error("rewrite");
	chk_rewrite_mask: assert property (rewrite_req |-> !cfg.mask_en) else $error("masked rewrite");
endmodule : wcrc_host_checker
bind wcrc_host wcrc_host_checker i_chk (.*);
`default_nettype wire

// *** wcrc_dev_model.sv ***
/* device model on the write pins: gathers ten-slot frames, rebuilds the
   checksum trees and pulls the alert low on a mismatch.
   assumes frames arrive back to back while the output enable is high. */
`timescale 1ns/1ps
`default_nettype none
module wcrc_dev_model
	import wcrc_pkg::*;
(
	input wire logic clk, rst_n, dq_oe, corrupt,
	input wire wr_cfg_t cfg,
	input wire logic [15:0] dq_out,
	input wire logic [1:0] side_out,
	output logic alert_n
);
	logic [15:0] dq_c [10];
	logic [1:0] sd_c [10];
	logic bad;
	int slot, hold;
	function automatic logic [7:0] ref_crc(input logic [71:0] d);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 71; i >= 0; i--)
			c = {c[6:0], 1'b0} ^ ({8{c[7] ^ d[i]}} & 8'h07);
		return c;
	endfunction : ref_crc
	// taken from the pins as driven, so inversion is never undone here
	function automatic logic [71:0] tree(input int ln);
		logic [71:0] t;
		for (int b = 0; b < 8; b++) begin
			for (int k = 0; k < 8; k++)
				t[k*8+b] = dq_c[b][ln*8+k];
			t[64+b] = sd_c[b][ln];
		end
		if (cfg.width == WIDTH_X4)
			t[71:32] = '1;
		return t;
	endfunction : tree
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			slot = 0;
			hold = 0;
			alert_n <= 1'b1;
		end else begin
			if (hold > 0)
				hold--;
			else
				alert_n <= 1'b1;
			if (dq_oe !== 1'b1 || !cfg.crc_en) begin
				// frames without a checksum are not checked
				slot = 0;
			end else begin
				dq_c[slot] = dq_out ^ {15'h0, corrupt && slot == 0};
				sd_c[slot] = side_out;
				slot++;
			end
			if (slot == 10) begin
				slot = 0;
				bad = ref_crc(tree(0)) != (cfg.width == WIDTH_X4 ? {dq_c[9][3:0], dq_c[8][3:0]} : dq_c[8][7:0]);
				if (cfg.width == WIDTH_X16 && ref_crc(tree(1)) != dq_c[8][15:8])
					bad = 1'b1;
				// alert only: no array is modelled, so commit or discard is not seen
				if (bad) begin
					alert_n <= 1'b0;
					hold = 3;
				end
			end
		end
	end
endmodule : wcrc_dev_model
`default_nettype wire

// *** tb_top.sv ***
/* bench for the host write framer with the device model on its pins.
   assumes the checker and the device model are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import wcrc_pkg::*;
;
	logic clk, rst_n, wr_valid, wr_ready, mpr_wr_req, per_dev_req, cfg_error, req_refused;
	logic dq_oe, wr_cmd, alert_n, rewrite_req, corrupt, seen;
	wr_cfg_t cfg;
	logic [127:0] wr_data;
	logic [71:0] t;
	logic [15:0] wr_mask, dq_out, crc_sent, exp, msk;
	logic [2:0] wr_col;
	logic [1:0] side_out;
	int fails, compares, n, oe;
	wcrc_host #(.DEPTH(FIFO_DEPTH)) i_dut (.*);
	wcrc_dev_model i_dev (.*);
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	task automatic tick();
		@(posedge clk);
		#1;
	endtask : tick
	task automatic check(input string what, input logic [15:0] e, input logic [15:0] g);
		compares++;
		if (g !== e) begin
			fails++;
			$display("Error %s expected %h seen %h", what, e, g);
		end
	endtask : check
	task automatic tally_and_finish();
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : tally_and_finish
	task automatic push(input logic [127:0] d, input logic [15:0] m);
		wr_data = d;
		wr_mask = m;
		wr_valid = 1'b1;
		for (n = 0; n < 40 && wr_ready !== 1'b1; n++)
			tick();
		if (n == 40) begin
			fails++;
			tally_and_finish();
		end
		tick();
		wr_valid = 1'b0;
		for (n = 0; n < 40 && wr_cmd !== 1'b1; n++)
			tick();
		if (n == 40) begin
			fails++;
			tally_and_finish();
		end
	endtask : push
	initial begin
		rst_n = 1'b0;
		cfg = '0;
		cfg.crc_en = 1'b1;
		{wr_valid, mpr_wr_req, per_dev_req, corrupt} = 4'h0;
		wr_data = '0;
		wr_mask = '0;
		fails = 0;
		compares = 0;
		repeat (12) @(posedge clk);
		#1;
		check("idle dq", 16'hffff, dq_out);
		rst_n = 1'b1;
		tick();
		// m: bit 0 corrupts the frame, m/2 picks none, masking or inversion
		for (int w = 0; w < 3; w++) begin
			for (int m = 0; m < 6; m++) begin
				cfg.width = part_width_t'(w);
				cfg.mask_en = m / 2 == 1;
				cfg.inv_en = m / 2 == 2;
				corrupt = m[0];
				push({4{32'h9e3779b9 * (w * 6 + m + 1)}}, 16'h5ac3 ^ 16'(w * 6 + m));
				msk = w == 2 ? 16'hffff : 16'h00ff;
				exp[7:0] = i_dev.ref_crc(w == 0 ? {40'hff_ffff_ffff, wr_data[31:0]}
					: {m > 1 ? wr_mask[7:0] : 8'hff, wr_data[63:0]});
				exp[15:8] = i_dev.ref_crc({m > 1 ? wr_mask[15:8] : 8'hff, wr_data[127:64]});
				tick();
				check("checksum", exp & msk, crc_sent & msk);
				seen = 1'b0;
				repeat (25) begin
					tick();
					seen |= rewrite_req === 1'b1;
				end
				check("rewrite", {15'h0, m == 1 || m == 5}, {15'h0, seen});
			end
		end
		for (int r = 0; r < 2; r++) begin
			{mpr_wr_req, per_dev_req} = r == 0 ? 2'h2 : 2'h1;
			tick();
			{mpr_wr_req, per_dev_req} = 2'h0;
			check("refused", 16'h1, {15'h0, req_refused});
		end
		// conflicting modes hold every burst back, which lets the buffer fill
		corrupt = 1'b0;
		cfg.mask_en = 1'b1;
		cfg.inv_en = 1'b1;
		tick();
		tick();
		check("conflict", 16'h1, {15'h0, cfg_error});
		wr_valid = 1'b1;
		for (n = 0; n < 40 && wr_ready === 1'b1; n++)
			tick();
		wr_valid = 1'b0;
		check("fill count", 16'(FIFO_DEPTH), 16'(n));
		cfg.inv_en = 1'b0;
		n = 0;
		repeat (300) begin
			tick();
			n += wr_cmd === 1'b1;
		end
		check("drain count", 16'(FIFO_DEPTH), 16'(n));
		// p: 0 one-clock preamble, 1 two-clock preamble, 2 chopped high nibble masked, 3 checksum off
		cfg = '0;
		cfg.width = WIDTH_X8;
		for (int p = 0; p < 4; p++) begin
			cfg.crc_en = p != 3;
			cfg.pre2 = p == 1;
			{cfg.chop, cfg.col2, cfg.mask_en} = {3{p == 2}};
			push(128'h0f1e_2d3c_4b5a_6978_8796_a5b4_c3d2_e1f0, 16'h3ca5);
			t = {8'hff, wr_data[63:0]};
			for (int b = 0; b < 8; b++) begin
				for (int k = 0; k < 9 && p == 2; k++) begin
					t[k*8+b] = b > 3 ? 1'b1 : k < 8 ? wr_data[k*8+b+4] : wr_mask[b+4];
				end
			end
			if (p != 3)
				check("mode checksum", {8'h0, i_dev.ref_crc(t)}, {8'h0, crc_sent[7:0]});
			// second burst straight behind the first to see the spacing
			wr_valid = 1'b1;
			tick();
			wr_valid = 1'b0;
			oe = 0;
			for (n = 1; n < 40 && wr_cmd !== 1'b1; n++) begin
				oe += dq_oe === 1'b1;
				tick();
			end
			check("frame length", p == 3 ? 16'(BEATS) : 16'(SLOTS), 16'(oe));
			check("spacing", 16'((p == 3 ? BEATS : SLOTS) + 2 + (p == 1)), 16'(n));
			seen = 1'b0;
			repeat (25) begin
				tick();
				seen |= rewrite_req === 1'b1;
			end
			check("mode rewrite", 16'h0, {15'h0, seen});
		end
		tally_and_finish();
	end
endmodule : tb_top
`default_nettype wire
